/* File: cce_pkg.sv */
/*
  Constants, types and helpers shared by the configurable CRC engine.
  Assumes an APB slave with 32-bit data and byte addresses in the low
  address bits; every register sits on an aligned word.
*/
// How it works
// - accumulator width is poly_length_field plus one, up to 16 bits.
// - top and bottom polynomial terms forced to one; middle from poly_coeff_reg.
// - poly_coeff_reg bit 0 reads zero but counts as one.
// - only input bits up to word_width_field are used, others ignored.
// - bit_order_select clear shifts MSb first, set shifts LSb first.
// - software seeds by writing check_accumulator before starting.
// - writing input_word_low loads the shifter; high byte alone starts nothing.
// - words pass through staging_shifter into the accumulator with XOR taps.
// - the result stays readable in check_accumulator bits 15:0.
// - data comes from software writes or from the memory scanner.
// - any polynomial up to 16 bits with a constant term of one is programmable.
// - augment_zeros_mode appends polynomial-length zero bits after the data.
// - check_done_flag sets on every busy fall, cleared only by software.
// - LSb-first plus augmentation leaves the result bit-reversed.
package cce_pkg;

  localparam int ACC_W = 16;
  localparam int FLD_W = 4;

  // register byte offsets
  localparam logic [7:0] CCE_CTRL0_OFS = 8'h00;
  localparam logic [7:0] CCE_CTRL1_OFS = 8'h04;
  localparam logic [7:0] CCE_POLY_OFS  = 8'h08;
  localparam logic [7:0] CCE_ACC_OFS   = 8'h0c;
  localparam logic [7:0] CCE_DATA_OFS  = 8'h10;
  localparam logic [7:0] CCE_STAT_OFS  = 8'h14;

  // check_control0 bit positions
  localparam int C0_EN   = 0;
  localparam int C0_GO   = 1;
  localparam int C0_BUSY = 2;
  localparam int C0_AUGM = 3;
  localparam int C0_LSB  = 4;
  localparam int C0_FULL = 5;

  // check_control1 field positions
  localparam int C1_WORD_WIDTH_FIELD_LSB = 0;
  localparam int C1_POLY_LENGTH_FIELD_LSB = 4;

  // status and byte lanes
  localparam int ST_DONE   = 0;
  localparam int LANE_LOW  = 0;
  localparam int LANE_HIGH = 1;

  // reset values and the forced polynomial bit 0
  localparam logic [15:0]      POLY_RST = 16'h0000;
  localparam logic [15:0]      ACC_RST  = 16'h0000;
  localparam logic [FLD_W-1:0] WORD_WIDTH_FIELD_RST = 4'h7;
  localparam logic [FLD_W-1:0] POLY_LENGTH_FIELD_RST = 4'hf;
  localparam logic [15:0]      POLY_LSB = 16'h0001;

  typedef enum logic [1:0] {
    CCE_IDLE  = 2'b00,
    CCE_SHIFT = 2'b01,
    CCE_AUGM  = 2'b11
  } cce_state_e;

  typedef struct packed {
    logic             aug;
    logic             lsb;
    logic [FLD_W-1:0] word_width_field;
    logic [FLD_W-1:0] poly_length_field;
  } cce_cfg_s;

  // ones in the low f+1 bits
  function automatic logic [15:0] cce_len_mask(input logic [FLD_W-1:0] f);
    cce_len_mask = 16'hffff >> (4'hf - f);
  endfunction

endpackage

/* File: cce_shifter.sv */
/*
  Staging shifter: holds one input word and hands it out bit by bit.
  Assumes the caller steps it only while a word is loaded and keeps the
  configuration steady for the length of a word.
*/
`timescale 1ns/1ns
`default_nettype none
module cce_shifter (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [15:0]      word,
  input  wire cce_pkg::cce_cfg_s cfg,
  input  wire logic             step,
  output logic                  bit_o,
  output logic                  last_o
);
  import cce_pkg::*;

  logic [15:0]      word_q;
  logic [FLD_W-1:0] cnt_q;
  logic [FLD_W-1:0] msb_idx;

  // bit pick: MSb end sits at the data length, not at bit 15
  assign msb_idx = cfg.word_width_field - cnt_q;
  assign bit_o   = cfg.lsb ? word_q[cnt_q] : word_q[msb_idx];
  assign last_o  = (cnt_q == cfg.word_width_field);

  // load masks away bits above the data length
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_q <= 16'h0000;
      cnt_q  <= 4'h0;
    end else if (load) begin
      word_q <= word & cce_len_mask(cfg.word_width_field);
      cnt_q  <= 4'h0;
    end else if (step) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

endmodule
`default_nettype wire

/* File: cce_accum.sv */
/*
  Check accumulator with XOR feedback taps.
  Assumes a seed write and a shift step never matter in the same cycle;
  the seed wins if they meet.
*/
`timescale 1ns/1ns
`default_nettype none
module cce_accum (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             seed_we,
  input  wire logic [15:0]      seed,
  input  wire logic             step,
  input  wire logic             din,
  input  wire cce_pkg::cce_cfg_s cfg,
  input  wire logic [15:0]      poly,
  output logic [15:0]           acc_o
);
  import cce_pkg::*;

  logic [15:0] acc_q;
  logic [15:0] mask;
  logic [15:0] taps;
  logic [15:0] shifted;
  logic        fb;

  // width follows the length field; x^n is the bit shifted out
  assign mask    = cce_len_mask(cfg.poly_length_field);
  assign taps    = (poly | POLY_LSB) & mask;
  assign fb      = acc_q[cfg.poly_length_field];
  assign shifted = {acc_q[14:0], din} & mask;
  assign acc_o   = acc_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= ACC_RST;
    end else if (seed_we) begin
      acc_q <= seed;
    end else if (step) begin
      acc_q <= fb ? (shifted ^ taps) : shifted;
    end
  end

endmodule
`default_nettype wire

/* File: cce_top.sv */
/*
  Configurable CRC engine with an APB register port and a scanner port.
  Assumes the scanner runs on the same clock and offers one word per
  strobe only while scan_full is low.
*/
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module cce_top #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          scan_wr,
  input  wire logic [15:0]   scan_word,
  output logic               scan_full,
  output logic               crc_go,
  output logic               crc_busy,
  output logic               check_done
);
  import cce_pkg::*;

  if (AW < 8) begin : g_aw_chk
    $error("cce_top: AW must be at least 8");
  end

  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
    hit = (a == AW'(ofs));
  endfunction

  // apb state
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;
  // control state
  logic             en_q;
  logic             go_q;
  logic             aug_q;
  logic             lsb_q;
  logic [FLD_W-1:0] word_width_field_q;
  logic [FLD_W-1:0] poly_length_field_q;
  logic [15:0]      poly_q;
  logic [15:0]      in_q;
  logic             pend_q;
  logic             aug_pend_q;
  logic [FLD_W-1:0] zcnt_q;
  logic             busy_q;
  logic             done_q;
  cce_state_e       state_q;
  cce_state_e       state_d;

  cce_cfg_s         cfg;
  logic [15:0]      acc;
  logic             sh_bit;
  logic             sh_last;

  // bus decode: one wait state, answer from flops
  logic             setup_acc;
  logic             wr_fire;
  logic             rd_sel;
  logic             h_c0;
  logic             h_c1;
  logic             h_poly;
  logic             h_acc;
  logic             h_data;
  logic             h_stat;
  logic             mapped;
  assign setup_acc = psel & penable & ~pready_q;
  assign wr_fire   = psel & penable & pready_q & pwrite;
  assign h_c0      = hit(paddr, CCE_CTRL0_OFS);
  assign h_c1      = hit(paddr, CCE_CTRL1_OFS);
  assign h_poly    = hit(paddr, CCE_POLY_OFS);
  assign h_acc     = hit(paddr, CCE_ACC_OFS);
  assign h_data    = hit(paddr, CCE_DATA_OFS);
  assign h_stat    = hit(paddr, CCE_STAT_OFS);
  assign mapped    = h_c0 | h_c1 | h_poly | h_acc | h_data | h_stat;
  assign rd_sel    = setup_acc & ~pwrite;

  // read view; unmapped reads give zero
  logic [31:0]      c0_view;
  logic [31:0]      c1_view;
  logic [31:0]      rdata_w;
  assign c0_view = (32'(en_q) << C0_EN) | (32'(go_q) << C0_GO)
                 | (32'(busy_q) << C0_BUSY) | (32'(aug_q) << C0_AUGM)
                 | (32'(lsb_q) << C0_LSB) | (32'(pend_q) << C0_FULL);
  assign c1_view = (32'(word_width_field_q) << C1_WORD_WIDTH_FIELD_LSB) | (32'(poly_length_field_q) << C1_POLY_LENGTH_FIELD_LSB);
  assign rdata_w = h_c0   ? c0_view :
                   h_c1   ? c1_view :
                   h_poly ? {16'h0000, poly_q} :
                   h_acc  ? {16'h0000, acc} :
                   h_data ? {16'h0000, in_q} :
                   h_stat ? (32'(done_q) << ST_DONE) : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_acc;
      pslverr_q <= setup_acc & ~mapped;
      if (rd_sel) begin
        prdata_q <= rdata_w;
      end
    end
  end

  // write strobes per register and lane
  logic             w_c0;
  logic             w_c1;
  logic             w_poly_l;
  logic             w_poly_h;
  logic             w_acc;
  logic             w_stat;
  logic             w_dat_l;
  logic             w_dat_h;
  logic             sw_trig;
  logic             sc_trig;
  logic             go_d;
  assign w_c0     = wr_fire & h_c0 & pstrb[LANE_LOW];
  assign w_c1     = wr_fire & h_c1 & pstrb[LANE_LOW];
  assign w_poly_l = wr_fire & h_poly & pstrb[LANE_LOW];
  assign w_poly_h = wr_fire & h_poly & pstrb[LANE_HIGH];
  assign w_acc    = wr_fire & h_acc & (pstrb[LANE_LOW] | pstrb[LANE_HIGH]);
  assign w_stat   = wr_fire & h_stat & pstrb[LANE_LOW] & pwdata[ST_DONE];
  // full input register refuses further words
  assign w_dat_l  = wr_fire & h_data & pstrb[LANE_LOW] & ~pend_q;
  assign w_dat_h  = wr_fire & h_data & pstrb[LANE_HIGH] & ~pend_q;
  assign sw_trig  = w_dat_l;
  assign sc_trig  = scan_wr & ~pend_q & ~w_dat_l & ~w_dat_h;
  assign go_d     = w_c0 ? (pwdata[C0_EN] & pwdata[C0_GO]) : go_q;

  // seed assembled per byte lane
  logic [15:0] seed_w;
  assign seed_w = {pstrb[LANE_HIGH] ? pwdata[15:8] : acc[15:8],
                   pstrb[LANE_LOW] ? pwdata[7:0] : acc[7:0]};

  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      go_q   <= 1'b0;
      aug_q  <= 1'b0;
      lsb_q  <= 1'b0;
      word_width_field_q <= WORD_WIDTH_FIELD_RST;
      poly_length_field_q <= POLY_LENGTH_FIELD_RST;
      poly_q <= POLY_RST;
    end else begin
      go_q <= go_d;
      if (w_c0) begin
        en_q  <= pwdata[C0_EN];
        aug_q <= pwdata[C0_AUGM];
        lsb_q <= pwdata[C0_LSB];
      end
      if (w_c1) begin
        word_width_field_q <= pwdata[C1_WORD_WIDTH_FIELD_LSB +: FLD_W];
        poly_length_field_q <= pwdata[C1_POLY_LENGTH_FIELD_LSB +: FLD_W];
      end
      // bit 0 is not stored
      if (w_poly_l) begin
        poly_q[7:0] <= pwdata[7:0] & ~POLY_LSB[7:0];
      end
      if (w_poly_h) begin
        poly_q[15:8] <= pwdata[15:8];
      end
    end
  end

  assign cfg = '{aug: aug_q, lsb: lsb_q, word_width_field: word_width_field_q, poly_length_field: poly_length_field_q};

  // engine control
  logic             load_sh;
  logic             step_sh;
  logic             step_acc;
  logic             din;
  logic             zlast;
  assign zlast    = (zcnt_q == poly_length_field_q);
  assign load_sh  = go_q & pend_q & ((state_q == CCE_IDLE)
                  | ((state_q == CCE_SHIFT) & sh_last));
  assign step_sh  = (state_q == CCE_SHIFT);
  assign step_acc = (state_q == CCE_SHIFT) | (state_q == CCE_AUGM);
  assign din      = (state_q == CCE_AUGM) ? 1'b0 : sh_bit;

  // next state: a waiting word beats the zero tail
  always_comb begin
    state_d = state_q;
    case (state_q)
      CCE_IDLE: begin
        if (load_sh) begin
          state_d = CCE_SHIFT;
        end else if (aug_pend_q) begin
          state_d = CCE_AUGM;
        end
      end
      CCE_SHIFT: begin
        if (sh_last & ~load_sh) begin
          state_d = CCE_IDLE;
        end
      end
      CCE_AUGM: begin
        if (zlast) begin
          state_d = CCE_IDLE;
        end
      end
      default: begin
        state_d = CCE_IDLE;
      end
    endcase
  end

  logic busy_d;
  assign busy_d = (state_d != CCE_IDLE) | (pend_q & go_q) | aug_pend_q;

  // input word, pending word and augmentation bookkeeping
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_q       <= 16'h0000;
      pend_q     <= 1'b0;
      aug_pend_q <= 1'b0;
      zcnt_q     <= 4'h0;
      state_q    <= CCE_IDLE;
    end else begin
      state_q <= state_d;
      if (w_dat_h) begin
        in_q[15:8] <= pwdata[15:8];
      end
      if (w_dat_l) begin
        in_q[7:0] <= pwdata[7:0];
      end
      if (sc_trig) begin
        in_q <= scan_word;
      end
      if (sw_trig | sc_trig) begin
        pend_q <= 1'b1;
      end else if (load_sh) begin
        pend_q <= 1'b0;
      end
      // zeros follow once software stops the run
      if (go_q & ~go_d & aug_q) begin
        aug_pend_q <= 1'b1;
      end else if ((state_q == CCE_AUGM) & zlast) begin
        aug_pend_q <= 1'b0;
      end
      if (state_q == CCE_AUGM) begin
        zcnt_q <= zcnt_q + 4'h1;
      end else begin
        zcnt_q <= 4'h0;
      end
    end
  end

  // done flag: set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      if (busy_q & ~busy_d) begin
        done_q <= 1'b1;
      end else if (w_stat) begin
        done_q <= 1'b0;
      end
    end
  end

  cce_shifter u_shift (
    .clk    (clk),
    .rst_n  (rst_n),
    .load   (load_sh),
    .word   (in_q),
    .cfg    (cfg),
    .step   (step_sh),
    .bit_o  (sh_bit),
    .last_o (sh_last)
  );

  cce_accum u_acc (
    .clk     (clk),
    .rst_n   (rst_n),
    .seed_we (w_acc),
    .seed    (seed_w),
    .step    (step_acc),
    .din     (din),
    .cfg     (cfg),
    .poly    (poly_q),
    .acc_o   (acc)
  );

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign scan_full  = pend_q;
  assign crc_go     = go_q;
  assign crc_busy   = busy_q;
  assign check_done = done_q;

endmodule
`default_nettype wire

/* File: cce_top_asserts.sv */
/* Port checker for cce_top, bound into every instance.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module cce_top_asserts import cce_pkg::*; #(parameter int AW = 8) (
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          scan_wr,
  input wire logic [15:0]   scan_word,
  input wire logic          scan_full,
  input wire logic          crc_go,
  input wire logic          crc_busy,
  input wire logic          check_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // completed transfers by kind
  wire xfer  = psel && penable && pready;
  wire dat_w = xfer && pwrite && paddr == AW'(CCE_DATA_OFS);
  wire clr_w = xfer && pwrite && paddr == AW'(CCE_STAT_OFS) && pwdata[ST_DONE];
  sequence setup_s; psel && !penable; endsequence
  sequence wait_s; psel && penable && !pready; endsequence
  apb_answer_a: assert property (setup_s ##1 wait_s |=> pready)
    else $error("pready not in second access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_decode_a: assert property (xfer && paddr[1:0] == 2'h0 |-> pslverr == (paddr > AW'(CCE_STAT_OFS)))
    else $error("pslverr wrong for address");
  poly_bit0_a: assert property (xfer && !pwrite && paddr == AW'(CCE_POLY_OFS) |-> !prdata[0])
    else $error("poly bit 0 reads one");
  done_set_a: assert property ($fell(crc_busy) && $past(rst_n) |-> check_done)
    else $error("done not set on busy fall");
  done_keep_a: assert property (check_done && !clr_w |=> check_done)
    else $error("done cleared without write");
  scan_take_a: assert property (scan_wr && !scan_full && !dat_w |=> scan_full)
    else $error("scanner word not taken");
  low_load_a: assert property (dat_w && pstrb[LANE_LOW] && !scan_full |=> scan_full)
    else $error("low byte write did not load");
  high_only_a: assert property (dat_w && !pstrb[LANE_LOW] && !scan_full && !scan_wr |=> !scan_full)
    else $error("high byte write started a word");
  word_moves_a: assert property ($rose(scan_full) && crc_go |-> ##[1:40] !scan_full)
    else $error("word stuck before shifter");
endmodule
bind cce_top cce_top_asserts #(.AW(AW)) cce_top_asserts_inst (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scan_wr(scan_wr), .scan_word(scan_word), .scan_full(scan_full),
  .crc_go(crc_go), .crc_busy(crc_busy), .check_done(check_done));
`default_nettype wire

/* File: cce_scan_model.sv */
/* Memory scanner stand-in: hands one word per strobe.
   Assumes the same clock as the engine; the bench calls send. */
`timescale 1ns/1ns
`default_nettype none
module cce_scan_model (
  input wire logic   clk,
  input wire logic   scan_full,
  output var logic        scan_wr,
  output var logic [15:0] scan_word
);
  initial begin
    scan_wr = 1'b0;
    scan_word = 16'h0000;
  end
  // wait for room, pulse one word, then scramble the idle bus
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    while (scan_full !== 1'b0) begin
      @(negedge clk);
    end
    @(posedge clk);
    scan_wr <= 1'b1;
    scan_word <= w;
    @(posedge clk);
    scan_wr <= 1'b0;
    scan_word <= ~w; // stale word must not look valid
  endtask
endmodule
`default_nettype wire

/* File: cce_top_tb.sv */
/* Self-checking bench for cce_top: register reads and CRC runs fed by
   APB and by the scanner model. Assumes the checker is bound in. */
`timescale 1ns/1ns
`default_nettype none
module cce_top_tb;
  import cce_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        scan_wr, scan_full, crc_go, crc_busy, check_done, m_lsb;
  logic [7:0]  paddr;
  logic [3:0]  pstrb, m_dl, m_pl;
  logic [31:0] pwdata, prdata, rs;
  logic [15:0] scan_word, m_acc, m_poly;
  logic [64:0] e;
  logic [64:0] expq[$];
  logic [15:0] wq[$];
  int          bad_count, check_count;
  cce_top #(.AW(8)) cce_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_wr(scan_wr),
    .scan_word(scan_word), .scan_full(scan_full), .crc_go(crc_go),
    .crc_busy(crc_busy), .check_done(check_done));
  cce_scan_model cce_scan_model_inst (.clk(clk), .scan_full(scan_full),
    .scan_wr(scan_wr), .scan_word(scan_word));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, got);
    check_count++;
    if (got !== ex) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one APB transfer, held until pready is seen at a falling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1) begin
      @(negedge clk);
    end
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, m, input logic err);
    expq.push_back({err, m, ex});
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic wait_q(input logic idle);
    repeat (2) @(negedge clk);
    while (scan_full !== 1'b0 || (idle && crc_busy !== 1'b0)) begin
      @(negedge clk);
    end
  endtask
  // reference shift step of the check accumulator
  task automatic mstep(input logic b);
    logic [15:0] mk;
    logic        fb;
    mk = 16'hffff >> (4'hf - m_pl);
    fb = m_acc[m_pl];
    m_acc = ({m_acc[14:0], b} & mk) ^ (fb ? (m_poly | 16'h0001) & mk : 16'h0000);
  endtask
  task automatic feed(input logic [15:0] w, input logic scan);
    logic [31:0] r;
    r = rnd();
    for (int i = 0; i <= m_dl; i++) mstep(m_lsb ? w[i] : w[m_dl - i]);
    wait_q(1'b0);
    if (scan) cce_scan_model_inst.send(w);
    else begin
      if (m_dl > 4'h7) begin
        apb(1'b1, CCE_DATA_OFS, {r[31:16], w}, 4'h2);
        repeat (3) @(negedge clk);
        chk("scan_full", 32'h0, {31'h0, scan_full});
      end
      apb(1'b1, CCE_DATA_OFS, {r[31:16], w}, 4'h1);
    end
    repeat (2) @(negedge clk);
    chk("crc_busy", 32'h1, {31'h0, crc_busy});
  endtask
  task automatic run(input logic [15:0] seed, poly, input logic [3:0] dl, pl,
                     input logic lsb, aug, scan);
    m_acc = seed;
    m_poly = poly;
    m_dl = dl;
    m_pl = pl;
    m_lsb = lsb;
    apb(1'b1, CCE_CTRL1_OFS, {24'h0, pl, dl}, 4'hf);
    apb(1'b1, CCE_POLY_OFS, {16'h0, poly}, 4'hf);
    apb(1'b1, CCE_ACC_OFS, {16'h0, seed}, 4'hf);
    apb(1'b1, CCE_CTRL0_OFS, {27'h0, lsb, aug, 3'h3}, 4'hf);
    @(negedge clk);
    chk("crc_go", 32'h1, {31'h0, crc_go});
    foreach (wq[i]) feed(wq[i], scan);
    wait_q(1'b1);
    apb(1'b1, CCE_CTRL0_OFS, {27'h0, lsb, aug, 3'h1}, 4'hf);
    if (aug) for (int i = 0; i <= pl; i++) mstep(1'b0);
    wait_q(1'b1);
    chk("crc_go", 32'h0, {31'h0, crc_go});
    chk("check_done", 32'h1, {31'h0, check_done});
    rd(CCE_ACC_OFS, {16'h0, m_acc}, 32'hffffffff, 1'b0);
    rd(CCE_STAT_OFS, 32'h1, 32'h1, 1'b0);
    apb(1'b1, CCE_STAT_OFS, 32'h1, 4'hf);
    rd(CCE_STAT_OFS, 32'h0, 32'h1, 1'b0);
    wq.delete();
  endtask
  // each completed read is checked against the oldest note
  always @(negedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      chk("prdata", e[31:0], prdata & e[63:32]);
      chk("pslverr", {31'h0, e[64]}, {31'h0, pslverr});
    end
  end
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    rs = 32'h00016141;
    bad_count = 0;
    check_count = 0;
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(CCE_CTRL1_OFS, 32'h000000f7, 32'hffffffff, 1'b0);
    rd(CCE_CTRL0_OFS, 32'h0, 32'h0000003f, 1'b0);
    rd(8'h18, 32'h0, 32'hffffffff, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rs = rnd();
      wq.push_back({rs[7:0], 8'h55 + 8'(i) * 8'h11});
    end
    run(16'h0000, 16'h8005, 4'h7, 4'hf, 1'b0, 1'b1, 1'b0);
    rd(CCE_POLY_OFS, 32'h00008004, 32'hffffffff, 1'b0);
    rd(CCE_ACC_OFS, 32'h000032d6, 32'hffffffff, 1'b0);
    for (int i = 0; i < 4; i++) wq.push_back(16'h0055 + 16'(i) * 16'h0011);
    run(16'h0000, 16'h8004, 4'h7, 4'hf, 1'b1, 1'b1, 1'b1);
    rd(CCE_ACC_OFS, 32'h00006ba2, 32'hffffffff, 1'b0);
    for (int k = 0; k < 6; k++) begin
      rs = rnd();
      for (int j = 0; j < 3; j++) wq.push_back(16'(rnd()));
      run(rs[15:0], rs[31:16], k[0] ? {1'b1, rs[2:0]} : rs[11:8], 4'hf - 4'(k * 3),
          rs[7], rs[12], k == 2 || k == 4);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
